// file: logic/oecr_regs.sv
// register bank and decode for the optical pulse / ecg sensor configuration
`timescale 1ns/1ps
module oecr_regs #(
  parameter logic [7:0] CHIP_ID = 8'h5a  // arbitrary value
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire oecr_pkg::oecr_byte_req_t i_bus,
  input  wire logic                    i_power_ready,
  input  wire logic                    i_pilot_mode,
  input  wire logic                    i_pilot_on_red,
  output logic [7:0]                   o_rd_data,
  output logic                         o_rd_valid,
  output logic                         o_int_n,
  output logic [16:0]                  o_red_ua,
  output logic [16:0]                  o_ir_ua,
  output logic [16:0]                  o_pilot_ua,
  output logic [11:0]                  o_ecg_rate_hz,
  output logic [3:0]                   o_pga_gain,
  output logic [8:0]                   o_instrument_amp_gain_x10
);
  import oecr_pkg::*;

  function automatic logic [16:0] drive_ua(input logic [7:0] code, input logic [1:0] rge);
    case (rge)
      OECR_RGE_50MA:  drive_ua = 17'(code) * OECR_STEP_LO_UA;
      OECR_RGE_100MA: drive_ua = 17'(code) * OECR_STEP_HI_UA;
      default:        drive_ua = 17'h00000;                     // undefined range drives nothing
    endcase
  endfunction

  function automatic logic [11:0] ecg_rate(input logic [2:0] sel);
    case (sel)
      3'h0:    ecg_rate = 12'h640;
      3'h1:    ecg_rate = 12'h320;
      3'h2:    ecg_rate = 12'h190;
      3'h3:    ecg_rate = 12'h0c8;
      3'h4:    ecg_rate = 12'hc80;
      3'h5:    ecg_rate = 12'h640;
      3'h6:    ecg_rate = 12'h320;
      default: ecg_rate = 12'h190;
    endcase
  endfunction

  function automatic logic [8:0] instrument_amp_gain(input logic [1:0] sel);
    case (sel)
      2'h0:    instrument_amp_gain = 9'h032;
      2'h1:    instrument_amp_gain = 9'h05f;
      2'h2:    instrument_amp_gain = 9'h0c8;
      default: instrument_amp_gain = 9'h1f4;
    endcase
  endfunction

  // ready level comes from the supply monitor, outside this clock
  logic rdy_s1_r, rdy_s2_r, rdy_s3_r;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
      rdy_s3_r <= 1'b0;
    end else begin
      rdy_s1_r <= i_power_ready;
      rdy_s2_r <= rdy_s1_r;
      rdy_s3_r <= rdy_s2_r;
    end
  end
  wire logic rdy_rise = rdy_s2_r & ~rdy_s3_r;

  // register file and pointer
  oecr_ptr_state_t st_r, st_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic [7:0] ir_amp_r, ir_amp_nxt, red_amp_r, red_amp_nxt, pilot_amp_r, pilot_amp_nxt;
  logic [7:0] range_r, range_nxt, ecg_rate_r, ecg_rate_nxt, ecg_gain_r, ecg_gain_nxt;
  logic       pend_r, pend_nxt;
  logic [7:0] rd_data_nxt;
  logic       data_wr, rd_hit, status_rd;

  always_comb begin
    st_nxt        = st_r;
    ptr_nxt       = ptr_r;
    ir_amp_nxt    = ir_amp_r;
    red_amp_nxt   = red_amp_r;
    pilot_amp_nxt = pilot_amp_r;
    range_nxt     = range_r;
    ecg_rate_nxt  = ecg_rate_r;
    ecg_gain_nxt  = ecg_gain_r;
    rd_data_nxt   = 8'h00;
    data_wr       = 1'b0;
    // a write in the same cycle wins, so the read strobe is dropped then
    rd_hit        = i_bus.rd_req & ~i_bus.start & ~i_bus.wr_valid;
    status_rd     = rd_hit & (ptr_r == OECR_OFF_INT_STATUS);
    if (i_bus.start) begin
      st_nxt = OECR_PTR_ADDR;
    end else if (i_bus.wr_valid) begin
      case (st_r)
        OECR_PTR_IDLE,
        OECR_PTR_ADDR: begin
          ptr_nxt = i_bus.wr_data;
          st_nxt  = OECR_PTR_DATA;
        end
        OECR_PTR_DATA: begin
          data_wr = 1'b1;
          ptr_nxt = ptr_r + 8'h01;
        end
        default: st_nxt = OECR_PTR_IDLE;
      endcase
    end else if (rd_hit) begin
      ptr_nxt = ptr_r + 8'h01;
    end
    if (data_wr) begin
      case (ptr_r)
        OECR_OFF_IR_AMP:    ir_amp_nxt    = i_bus.wr_data;
        OECR_OFF_RED_AMP:   red_amp_nxt   = i_bus.wr_data;
        OECR_OFF_PILOT_AMP: pilot_amp_nxt = i_bus.wr_data;
        OECR_OFF_RANGE:     range_nxt     = i_bus.wr_data & OECR_MASK_RANGE;
        OECR_OFF_ECG_RATE:  ecg_rate_nxt  = i_bus.wr_data & OECR_MASK_ECG_RATE;
        OECR_OFF_ECG_GAIN:  ecg_gain_nxt  = i_bus.wr_data & OECR_MASK_ECG_GAIN;
        default: ;                                              // id, status and unmapped offsets
      endcase
    end
    case (ptr_r)
      OECR_OFF_INT_STATUS: rd_data_nxt = 8'(pend_r) << OECR_POS_PWR_RDY;
      OECR_OFF_IR_AMP:     rd_data_nxt = ir_amp_r;
      OECR_OFF_RED_AMP:    rd_data_nxt = red_amp_r;
      OECR_OFF_PILOT_AMP:  rd_data_nxt = pilot_amp_r;
      OECR_OFF_RANGE:      rd_data_nxt = range_r;
      OECR_OFF_ECG_RATE:   rd_data_nxt = ecg_rate_r;
      OECR_OFF_ECG_GAIN:   rd_data_nxt = ecg_gain_r;
      OECR_OFF_CHIP_ID:    rd_data_nxt = CHIP_ID;
      default:             rd_data_nxt = 8'h00;
    endcase
    // a ready edge in the same cycle as the clearing read is kept
    pend_nxt = rdy_rise | (pend_r & ~status_rd);
  end

  // decoded drive and analog settings
  logic [1:0]  red_rge, ir_rge, pilot_rge;
  logic [16:0] red_ua_nxt, ir_ua_nxt, pilot_ua_nxt;
  logic [11:0] rate_nxt;
  logic [3:0]  pga_nxt;
  logic [8:0]  ia_nxt;
  always_comb begin
    red_rge      = range_r[OECR_POS_RED_RGE +: 2];
    ir_rge       = range_r[OECR_POS_IR_RGE +: 2];
    pilot_rge    = i_pilot_on_red ? red_rge : ir_rge;
    red_ua_nxt   = drive_ua(red_amp_r, red_rge);
    ir_ua_nxt    = drive_ua(ir_amp_r, ir_rge);
    pilot_ua_nxt = i_pilot_mode ? drive_ua(pilot_amp_r, pilot_rge) : 17'h00000;
    rate_nxt     = ecg_rate({ecg_rate_r[OECR_POS_ECG_CLK], ecg_rate_r[OECR_POS_ECG_OSR +: 2]});
    pga_nxt      = 4'h1 << ecg_gain_r[OECR_POS_PGA_GAIN +: 2];
    ia_nxt       = instrument_amp_gain(ecg_gain_r[OECR_POS_INSTRUMENT_AMP_GAIN +: 2]);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r          <= OECR_PTR_IDLE;
      ptr_r         <= OECR_OFF_INT_STATUS;
      ir_amp_r      <= OECR_RST_AMP;
      red_amp_r     <= OECR_RST_AMP;
      pilot_amp_r   <= OECR_RST_AMP;
      range_r       <= OECR_RST_RANGE;
      ecg_rate_r    <= OECR_RST_ECG_RATE;
      ecg_gain_r    <= OECR_RST_ECG_GAIN;
      pend_r        <= 1'b0;
      o_int_n       <= 1'b1;
      o_rd_data     <= OECR_RST_RD_DATA;
      o_rd_valid    <= 1'b0;
      o_red_ua      <= 17'h00000;
      o_ir_ua       <= 17'h00000;
      o_pilot_ua    <= 17'h00000;
      o_ecg_rate_hz <= 12'h640;
      o_pga_gain    <= 4'h1;
      o_instrument_amp_gain_x10 <= 9'h0c8;
    end else begin
      st_r          <= st_nxt;
      ptr_r         <= ptr_nxt;
      ir_amp_r      <= ir_amp_nxt;
      red_amp_r     <= red_amp_nxt;
      pilot_amp_r   <= pilot_amp_nxt;
      range_r       <= range_nxt;
      ecg_rate_r    <= ecg_rate_nxt;
      ecg_gain_r    <= ecg_gain_nxt;
      pend_r        <= pend_nxt;
      o_int_n       <= ~pend_nxt;
      o_rd_data     <= rd_hit ? rd_data_nxt : o_rd_data;
      o_rd_valid    <= rd_hit;
      o_red_ua      <= red_ua_nxt;
      o_ir_ua       <= ir_ua_nxt;
      o_pilot_ua    <= pilot_ua_nxt;
      o_ecg_rate_hz <= rate_nxt;
      o_pga_gain    <= pga_nxt;
      o_instrument_amp_gain_x10 <= ia_nxt;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence ready_edge_s;
    rdy_s2_r && !rdy_s3_r;
  endsequence
  sequence irq_low_s;
    !o_int_n && pend_r;
  endsequence

  ready_irq_a: assert property (ready_edge_s |=> irq_low_s) else $error("ready edge did not raise interrupt");
  status_clr_a: assert property (status_rd && !rdy_rise |=> pend_r == 1'b0 && o_int_n)
    else $error("status read did not clear interrupt");
  ptr_step_a: assert property (data_wr |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer did not advance after data byte");
  red_store_a: assert property (data_wr && ptr_r == OECR_OFF_RED_AMP |=> red_amp_r == $past(i_bus.wr_data))
    else $error("red amplitude not stored");
  chip_id_a: assert property (rd_hit && ptr_r == OECR_OFF_CHIP_ID |=> o_rd_valid && o_rd_data == CHIP_ID)
    else $error("chip identifier read wrong");
  red_drive_a: assert property ($past(range_r[3:2]) == 2'h0 |->
                                 o_red_ua == 17'($past(red_amp_r)) * 17'd200)
    else $error("red drive current wrong in low range");
  ir_drive_a: assert property ($past(range_r[1:0]) == 2'h1 |-> o_ir_ua == 17'($past(ir_amp_r)) * 17'd400)
    else $error("infrared drive current wrong in high range");
  pilot_sel_a: assert property (i_pilot_mode && i_pilot_on_red |=> o_pilot_ua ==
                                 (($past(range_r[3:2]) == 2'h0) ? 17'($past(pilot_amp_r)) * 17'd200 :
                                  ($past(range_r[3:2]) == 2'h1) ? 17'($past(pilot_amp_r)) * 17'd400 : 17'h00000))
    else $error("pilot drive did not use red range");
  ecg_rate_a: assert property (ecg_rate_r[2:0] == 3'h4 |=> o_ecg_rate_hz == 12'd3200)
    else $error("ecg rate decode wrong");
  gain_dec_a: assert property (ecg_gain_r[3:0] == 4'hd |=> o_pga_gain == 4'd8 && o_instrument_amp_gain_x10 == 9'd95)
    else $error("gain decode wrong");
  unused_zero_a: assert property (range_r[7:4] == 4'h0 && ecg_rate_r[7:3] == 5'h00 && ecg_gain_r[7:4] == 4'h0)
    else $error("unused bits not zero");
endmodule

// file: logic/oecr_pkg.sv
// constants, field layout and carrier types for the optical/ecg config registers
package oecr_pkg;
  // register offsets
  localparam logic [7:0] OECR_OFF_INT_STATUS = 8'h00;
  localparam logic [7:0] OECR_OFF_IR_AMP     = 8'h11;
  localparam logic [7:0] OECR_OFF_RED_AMP    = 8'h12;
  localparam logic [7:0] OECR_OFF_RANGE      = 8'h14;
  localparam logic [7:0] OECR_OFF_PILOT_AMP  = 8'h15;
  localparam logic [7:0] OECR_OFF_ECG_RATE   = 8'h3c;
  localparam logic [7:0] OECR_OFF_ECG_GAIN   = 8'h3e;
  localparam logic [7:0] OECR_OFF_CHIP_ID    = 8'hff;
  // writable bit masks, unused positions stay zero
  localparam logic [7:0] OECR_MASK_RANGE     = 8'h0f;
  localparam logic [7:0] OECR_MASK_ECG_RATE  = 8'h07;
  localparam logic [7:0] OECR_MASK_ECG_GAIN  = 8'h0f;
  // field positions
  localparam int OECR_POS_RED_RGE   = 2;
  localparam int OECR_POS_IR_RGE    = 0;
  localparam int OECR_POS_ECG_CLK   = 2;
  localparam int OECR_POS_ECG_OSR   = 0;
  localparam int OECR_POS_PGA_GAIN  = 2;
  localparam int OECR_POS_INSTRUMENT_AMP_GAIN   = 0;
  localparam int OECR_POS_PWR_RDY   = 0;
  // values after reset
  localparam logic [7:0] OECR_RST_AMP       = 8'h00;
  localparam logic [7:0] OECR_RST_RANGE     = 8'h00;
  localparam logic [7:0] OECR_RST_ECG_RATE  = 8'h00;
  localparam logic [7:0] OECR_RST_ECG_GAIN  = 8'h02;
  localparam logic [7:0] OECR_RST_RD_DATA   = 8'h00;
  // drive current step per code, in microamps, and the range field codes
  localparam logic [16:0] OECR_STEP_LO_UA   = 17'h000c8;
  localparam logic [16:0] OECR_STEP_HI_UA   = 17'h00190;
  localparam logic [1:0]  OECR_RGE_50MA     = 2'h0;
  localparam logic [1:0]  OECR_RGE_100MA    = 2'h1;

  typedef enum logic [1:0] {
    OECR_PTR_IDLE = 2'b00,
    OECR_PTR_ADDR = 2'b01,
    OECR_PTR_DATA = 2'b10
  } oecr_ptr_state_t;

  // one byte event from the serial engine
  typedef struct packed {
    logic       start;
    logic       wr_valid;
    logic [7:0] wr_data;
    logic       rd_req;
  } oecr_byte_req_t;
endpackage

// file: sim/oecr_host_model.sv
// host-side model that feeds byte events into the config register bank
`timescale 1ns/1ps
module oecr_host_model (
  input  wire logic                     i_clk,
  input  wire logic [7:0]               i_rd_data,
  input  wire logic                     i_rd_valid,
  output oecr_pkg::oecr_byte_req_t      o_bus
);
  import oecr_pkg::*;
  initial o_bus = '0;
  // one request, then an idle cycle so no field is assigned twice in a time step
  task automatic pulse(input logic s, input logic w, input logic [7:0] dat, input logic r,
                       output logic [7:0] rd, output logic vld);
    o_bus = '{start: s, wr_valid: w, wr_data: dat, rd_req: r};
    @(posedge i_clk);
    #5;
    rd = i_rd_data;
    vld = i_rd_valid;
    // released data shows the inverse, never a stale copy
    o_bus = '{start: 1'b0, wr_valid: 1'b0, wr_data: ~dat, rd_req: 1'b0};
    @(posedge i_clk);
    #5;
  endtask
  task automatic set_ptr(input logic [7:0] a);
    logic [7:0] rd;
    logic       vld;
    pulse(1'b1, 1'b0, 8'h00, 1'b0, rd, vld);
    pulse(1'b0, 1'b1, a, 1'b0, rd, vld);
  endtask
  task automatic wdat(input logic [7:0] dat);
    logic [7:0] rd;
    logic       vld;
    pulse(1'b0, 1'b1, dat, 1'b0, rd, vld);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    set_ptr(a);
    wdat(dat);
  endtask
  task automatic rd(output logic [7:0] dat, output logic vld);
    pulse(1'b0, 1'b0, 8'h00, 1'b1, dat, vld);
  endtask
  // readiness is acknowledged only by reading the status byte
  task automatic ack(output logic [7:0] dat, output logic vld);
    set_ptr(OECR_OFF_INT_STATUS);
    rd(dat, vld);
  endtask
endmodule

// file: sim/oecr_regs_tb.sv
// self-checking bench for the optical/ecg config register bank
`timescale 1ns/1ps
module oecr_regs_tb;
  import oecr_pkg::*;
  localparam logic [7:0] TB_CHIP_ID = 8'h3c;  // arbitrary value
  logic           i_clk, i_sys_rst, i_power_ready, i_pilot_mode, i_pilot_on_red;
  oecr_byte_req_t bus;
  logic [7:0]     o_rd_data, d;
  logic           o_rd_valid, o_int_n, v;
  logic [16:0]    o_red_ua, o_ir_ua, o_pilot_ua;
  logic [11:0]    o_ecg_rate_hz;
  logic [3:0]     o_pga_gain;
  logic [8:0]     o_instrument_amp_gain_x10;
  int             err_count, comparisons, cycles;
  int             rate_hz[8] = '{1600, 800, 400, 200, 3200, 1600, 800, 400};
  int             ia_x10[4]  = '{50, 95, 200, 500};
  oecr_regs #(.CHIP_ID(TB_CHIP_ID)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(bus),
    .i_power_ready(i_power_ready), .i_pilot_mode(i_pilot_mode), .i_pilot_on_red(i_pilot_on_red),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_int_n(o_int_n), .o_red_ua(o_red_ua),
    .o_ir_ua(o_ir_ua), .o_pilot_ua(o_pilot_ua), .o_ecg_rate_hz(o_ecg_rate_hz),
    .o_pga_gain(o_pga_gain), .o_instrument_amp_gain_x10(o_instrument_amp_gain_x10));
  oecr_host_model host (.i_clk(i_clk), .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid), .o_bus(bus));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic print_verdict;
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard, the whole sequence needs well under a thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.set_ptr(a);
    host.rd(d, v);
    chk(v, 1'b1);
    chk(d, exp);
  endtask
  task automatic tick;
    @(posedge i_clk);
    #5;
  endtask
  function automatic logic [16:0] cur(input logic [7:0] code, input logic [1:0] rg);
    return (rg == 2'h0) ? code * 17'd200 : (rg == 2'h1) ? code * 17'd400 : 17'h0;
  endfunction
  initial begin
    i_sys_rst = 1'b1;
    i_power_ready = 1'b0;
    i_pilot_mode = 1'b0;
    i_pilot_on_red = 1'b0;
    repeat (12) @(posedge i_clk);
    #5;
    i_sys_rst = 1'b0;
    chk(o_int_n, 1'b1);
    chk(o_ecg_rate_hz, 17'd1600);
    chk(o_instrument_amp_gain_x10, 17'd200);
    chk(o_pga_gain, 17'd1);
    rdchk(8'h3e, 8'h02);
    rdchk(8'h15, 8'h00);
    rdchk(8'h3c, 8'h00);
    host.wr(8'hff, ~TB_CHIP_ID);
    rdchk(8'hff, TB_CHIP_ID);
    i_power_ready = 1'b1;
    repeat (8) if (o_int_n !== 1'b0) tick();
    chk(o_int_n, 1'b0);
    host.ack(d, v);
    chk(d[0], 1'b1);
    chk(o_int_n, 1'b1);
    rdchk(8'h00, 8'h00);
    // burst from 0x11; the byte landing on unmapped 0x13 must vanish
    host.set_ptr(8'h11);
    host.wdat(8'h81);
    host.wdat(8'hff);
    host.wdat(8'h77);
    host.wdat(8'hf4);
    host.wdat(8'h33);
    rdchk(8'h13, 8'h00);
    rdchk(8'h14, 8'h04);
    rdchk(8'h11, 8'h81);
    chk(o_red_ua, cur(8'hff, 2'h1));
    chk(o_ir_ua, cur(8'h81, 2'h0));
    i_pilot_mode = 1'b1;
    i_pilot_on_red = 1'b1;
    tick();
    tick();
    chk(o_pilot_ua, cur(8'h33, 2'h1));
    i_pilot_on_red = 1'b0;
    tick();
    tick();
    chk(o_pilot_ua, cur(8'h33, 2'h0));
    i_pilot_mode = 1'b0;
    tick();
    tick();
    chk(o_pilot_ua, 17'h0);
    // walk every mode and led pairing; red range is 01, infrared 00 here
    for (int k = 0; k < 4; k++) begin
      i_pilot_mode = !k[1];
      i_pilot_on_red = !k[0];
      tick();
      tick();
      chk(o_pilot_ua, k[1] ? 17'h0 : cur(8'h33, {1'b0, !k[0]}));
    end
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h14, {4'hf, 2'(k), 2'(k)});
      chk(o_red_ua, cur(8'hff, 2'(k)));
      chk(o_ir_ua, cur(8'h81, 2'(k)));
    end
    for (int k = 0; k < 8; k++) begin
      host.wr(8'h3c, {5'h1f, 3'(k)});
      chk(o_ecg_rate_hz, 17'(rate_hz[k]));
      rdchk(8'h3c, 8'(k));
    end
    for (int k = 0; k < 16; k++) begin
      host.wr(8'h3e, {4'hf, 4'(k)});
      chk(o_pga_gain, 17'd1 << (k / 4));
      chk(o_instrument_amp_gain_x10, 17'(ia_x10[k % 4]));
    end
    rdchk(8'h3e, 8'h0f);
    // mid-run reset: settings return, and a fresh ready edge fires again
    i_power_ready = 1'b0;
    i_sys_rst = 1'b1;
    repeat (3) tick();
    i_sys_rst = 1'b0;
    chk(o_int_n, 1'b1);
    chk(o_red_ua, 17'h0);
    chk(o_instrument_amp_gain_x10, 17'd200);
    rdchk(8'h14, 8'h00);
    i_power_ready = 1'b1;
    repeat (8) if (o_int_n !== 1'b0) tick();
    chk(o_int_n, 1'b0);
    host.ack(d, v);
    chk(d[0], 1'b1);
    chk(o_int_n, 1'b1);
    print_verdict();
  end
endmodule
